//--- cam_decoder_params.svh
// Constants for the addressing mode decoder
`ifndef CAM_DECODER_PARAMS_SVH
`define CAM_DECODER_PARAMS_SVH

// ----------------------------------------------------------------------------
// Prefix bytes
// ----------------------------------------------------------------------------
`define CAM_PREFIX_SECOND_INDEX 8'h90
`define CAM_PREFIX_SECOND_INDIRECT 8'h91
`define CAM_PREFIX_INDIRECT 8'h92

// ----------------------------------------------------------------------------
// Interrupt mask opcodes and levels
// ----------------------------------------------------------------------------
`define CAM_OP_MASK_INTERRUPTS 8'h9b
`define CAM_OP_UNMASK_INTERRUPTS 8'h9a
`define CAM_MASK_LEVEL_SET 2'h3
`define CAM_MASK_LEVEL_CLEAR 2'h0
`define CAM_MASK_RESET 2'h3

// ----------------------------------------------------------------------------
// Opcode rows (high nibble)
// ----------------------------------------------------------------------------
`define CAM_ROW_BIT_REL 4'h0
`define CAM_ROW_BIT 4'h1
`define CAM_ROW_REL 4'h2
`define CAM_ROW_RMW_DIR 4'h3
`define CAM_ROW_INH_A 4'h4
`define CAM_ROW_INH_X 4'h5
`define CAM_ROW_RMW_IDX_S 4'h6
`define CAM_ROW_RMW_IDX_0 4'h7
`define CAM_ROW_INH_MISC0 4'h8
`define CAM_ROW_INH_MISC1 4'h9
`define CAM_ROW_IMM 4'ha
`define CAM_ROW_DIR_S 4'hb
`define CAM_ROW_DIR_L 4'hc
`define CAM_ROW_IDX_L 4'hd
`define CAM_ROW_IDX_S 4'he
`define CAM_ROW_IDX_0 4'hf

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define CAM_PAGE_ZERO_HI 8'h00
`define CAM_ADDR_RESET 16'h0000
`define CAM_ROW_MSB 7
`define CAM_ROW_LSB 4
`define CAM_SIGN_BIT 7

`endif

//--- cam_decoder_pkg.sv
// Types shared by the addressing mode decoder
`default_nettype none

package cam_decoder_pkg;

  // --------------------------------------------------------------------------
  // Addressing modes, seventeen in seven groups
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    CAM_INH, CAM_IMM,
    CAM_DIR_S, CAM_DIR_L,
    CAM_IDX_0, CAM_IDX_S, CAM_IDX_L,
    CAM_IND_S, CAM_IND_L, CAM_IIX_S, CAM_IIX_L,
    CAM_REL_D, CAM_REL_I,
    CAM_BIT_D, CAM_BIT_I, CAM_BIT_DR, CAM_BIT_IR
  } cam_mode_t;

  typedef enum logic [1:0] {
    CAM_PFX_NONE, CAM_PFX_SECOND, CAM_PFX_INDIRECT, CAM_PFX_SECOND_INDIRECT
  } cam_prefix_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } cam_mem_req_t;

  typedef struct packed {
    cam_mode_t mode;
    logic [2:0] length;
    logic [15:0] effAddr;
    logic [15:0] branchTarget;
    logic useSecond;
    logic illegal;
  } cam_result_t;

endpackage : cam_decoder_pkg

`default_nettype wire

//--- cam_ea_adder.sv
// Registered 16-bit unsigned address adder
`default_nettype none

module cam_ea_adder
  import cam_decoder_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Operands
  input wire logic [15:0] augend,
  input wire logic [15:0] addend,
  // Registered sum
  output logic [15:0] sum
);

  // Wraps inside the 64 Kbyte space
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum <= 16'h0000;
    end else begin
      sum <= augend + addend;
    end
  end

endmodule : cam_ea_adder

`default_nettype wire

//--- cam_addr_decoder.sv
// Instruction length and effective address decoder
//
// Contract
// - Seventeen addressing modes in seven groups are decoded.
// - Long forms reach all 64 Kbyte using two-byte address words or two-byte pointers.
// - Short forms use byte addresses, reaching at most 1FE; direct and indexed ones are more compact.
// - Read-modify-write opcodes only ever decode to short or no-offset forms.
// - Inherent instructions are a single opcode byte.
// - Immediate instructions are opcode plus one operand byte.
// - Short direct uses one address byte, range 00 to FF.
// - Long direct uses a two-byte address word.
// - Indexed address is unsigned sum of chosen index and offset.
// - Indexed without offset uses the index alone, no operand byte.
// - Short indexed adds one offset byte, reaching up to 1FE.
// - Long indexed adds a two-byte offset word to the index.
// - Short indirect fetches a one-byte pointer from page zero.
// - Long indirect forms fetch a two-byte pointer from page zero.
// - Indirect indexed adds index to the fetched pointer, unsigned.
// - Short indirect indexed: byte pointer plus index, up to 1FE.
// - Mask op sets interrupt level 3, unmask op sets level 0.
// - Relative modes add a signed 8-bit offset to the PC.
// - Prefixes 90, 92, 91 select second index and indirect forms.
`include "cam_decoder_params.svh"
`default_nettype none

module cam_addr_decoder
  import cam_decoder_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sequencer request
  input wire logic startReq,
  input wire logic [15:0] startPc,
  input wire logic [7:0] indexFirst,
  input wire logic [7:0] indexSecond,
  // Sequencer answer
  output logic busy,
  output logic done,
  output cam_result_t result,
  output logic [1:0] intMask,
  // Memory bus
  output cam_mem_req_t memBus,
  input wire logic [7:0] memRdata,
  input wire logic memAck
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_OPERAND, ST_POINTER, ST_CALC, ST_DONE
  } cam_state_t;

  cam_state_t state;
  logic [15:0] pc;
  cam_prefix_t prefix;
  logic [7:0] opcode;
  cam_mode_t mode;
  logic illegal;
  logic [1:0] opCnt;
  logic [1:0] opIdx;
  logic [1:0] ptrIdx;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [15:0] ptr;
  logic [7:0] idxFirst;
  logic [7:0] idxSecond;
  logic [15:0] eaSum;

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic cam_mode_t decodeMode(input logic [3:0] row, input cam_prefix_t pfx);
    logic ind;
    cam_mode_t m;
    ind = (pfx == CAM_PFX_INDIRECT) || (pfx == CAM_PFX_SECOND_INDIRECT);
    case (row)
      `CAM_ROW_BIT_REL: m = ind ? CAM_BIT_IR : CAM_BIT_DR;
      `CAM_ROW_BIT: m = ind ? CAM_BIT_I : CAM_BIT_D;
      `CAM_ROW_REL: m = ind ? CAM_REL_I : CAM_REL_D;
      `CAM_ROW_RMW_DIR: m = ind ? CAM_IND_S : CAM_DIR_S;
      `CAM_ROW_RMW_IDX_S: m = ind ? CAM_IIX_S : CAM_IDX_S;
      `CAM_ROW_RMW_IDX_0: m = CAM_IDX_0;
      `CAM_ROW_IMM: m = CAM_IMM;
      `CAM_ROW_DIR_S: m = ind ? CAM_IND_S : CAM_DIR_S;
      `CAM_ROW_DIR_L: m = ind ? CAM_IND_L : CAM_DIR_L;
      `CAM_ROW_IDX_L: m = ind ? CAM_IIX_L : CAM_IDX_L;
      `CAM_ROW_IDX_S: m = ind ? CAM_IIX_S : CAM_IDX_S;
      `CAM_ROW_IDX_0: m = CAM_IDX_0;
      default: m = CAM_INH;
    endcase
    return m;
  endfunction : decodeMode

  // Prefix legality per opcode row
  function automatic logic badPrefix(input logic [3:0] row, input cam_prefix_t pfx);
    logic indexedRow;
    logic directRow;
    logic bad;
    indexedRow = (row == `CAM_ROW_RMW_IDX_S) || (row == `CAM_ROW_IDX_L) || (row == `CAM_ROW_IDX_S);
    directRow = (row == `CAM_ROW_BIT_REL) || (row == `CAM_ROW_BIT) || (row == `CAM_ROW_REL) ||
                (row == `CAM_ROW_RMW_DIR) || (row == `CAM_ROW_DIR_S) || (row == `CAM_ROW_DIR_L);
    case (pfx)
      CAM_PFX_SECOND: bad = directRow;
      CAM_PFX_INDIRECT: bad = !(directRow || indexedRow);
      CAM_PFX_SECOND_INDIRECT: bad = !indexedRow;
      default: bad = 1'b0;
    endcase
    return bad;
  endfunction : badPrefix

  // Operand bytes after the opcode
  function automatic logic [1:0] operandCount(input cam_mode_t m);
    logic [1:0] n;
    case (m)
      CAM_INH, CAM_IDX_0: n = 2'h0;
      CAM_IMM: n = 2'h1;
      CAM_DIR_S, CAM_IDX_S: n = 2'h1;
      CAM_DIR_L, CAM_IDX_L: n = 2'h2;
      CAM_IND_S, CAM_IND_L, CAM_IIX_S, CAM_IIX_L: n = 2'h1;
      CAM_BIT_DR, CAM_BIT_IR: n = 2'h2;
      default: n = 2'h1;
    endcase
    return n;
  endfunction : operandCount

  // Pointer bytes fetched from page zero
  function automatic logic [1:0] pointerCount(input cam_mode_t m);
    logic [1:0] n;
    case (m)
      CAM_IND_S, CAM_IIX_S, CAM_REL_I, CAM_BIT_I, CAM_BIT_IR: n = 2'h1;
      CAM_IND_L, CAM_IIX_L: n = 2'h2;
      default: n = 2'h0;
    endcase
    return n;
  endfunction : pointerCount

  function automatic cam_prefix_t prefixOf(input logic [7:0] b);
    cam_prefix_t p;
    case (b)
      `CAM_PREFIX_SECOND_INDEX: p = CAM_PFX_SECOND;
      `CAM_PREFIX_INDIRECT: p = CAM_PFX_INDIRECT;
      `CAM_PREFIX_SECOND_INDIRECT: p = CAM_PFX_SECOND_INDIRECT;
      default: p = CAM_PFX_NONE;
    endcase
    return p;
  endfunction : prefixOf

  // --------------------------------------------------------------------------
  // Combinational decode of the incoming byte
  // --------------------------------------------------------------------------
  logic byteIn;
  logic fetching;
  logic useSecond;
  logic [7:0] indexSel;
  logic [3:0] rowIn;
  cam_mode_t modeIn;
  logic [1:0] cntIn;
  logic [15:0] fetchAddr;
  logic [15:0] augend;
  logic [15:0] addend;

  assign byteIn = memBus.req && memAck;
  assign fetching = (state == ST_OPCODE) || (state == ST_OPERAND) || (state == ST_POINTER);
  assign rowIn = memRdata[`CAM_ROW_MSB:`CAM_ROW_LSB];
  assign modeIn = decodeMode(rowIn, prefix);
  assign cntIn = operandCount(modeIn);
  assign useSecond = (prefix == CAM_PFX_SECOND) || (prefix == CAM_PFX_SECOND_INDIRECT);
  assign indexSel = useSecond ? idxSecond : idxFirst;

  // Pointers live in page zero; word pointer is read high byte first
  always_comb begin
    if (state == ST_POINTER) begin
      fetchAddr = {`CAM_PAGE_ZERO_HI, byte0} + {14'h0000, ptrIdx};
    end else begin
      fetchAddr = pc;
    end
  end

  // Adder operands per mode
  always_comb begin
    augend = `CAM_ADDR_RESET;
    addend = `CAM_ADDR_RESET;
    case (mode)
      CAM_IMM: augend = pc - 16'h0001;
      CAM_DIR_S, CAM_BIT_D, CAM_BIT_DR: augend = {`CAM_PAGE_ZERO_HI, byte0};
      CAM_DIR_L: augend = {byte0, byte1};
      CAM_IDX_0: addend = {8'h00, indexSel};
      CAM_IDX_S: begin
        augend = {`CAM_PAGE_ZERO_HI, byte0};
        addend = {8'h00, indexSel};
      end
      CAM_IDX_L: begin
        augend = {byte0, byte1};
        addend = {8'h00, indexSel};
      end
      CAM_IND_S, CAM_IND_L, CAM_BIT_I, CAM_BIT_IR: augend = ptr;
      CAM_IIX_S, CAM_IIX_L: begin
        augend = ptr;
        addend = {8'h00, indexSel};
      end
      CAM_REL_D: begin
        augend = pc;
        addend = {{8{byte0[`CAM_SIGN_BIT]}}, byte0};
      end
      CAM_REL_I: begin
        augend = pc;
        addend = {{8{ptr[`CAM_SIGN_BIT]}}, ptr[7:0]};
      end
      default: augend = `CAM_ADDR_RESET;
    endcase
  end

  cam_ea_adder u_adder (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .augend(augend),
    .addend(addend),
    .sum(eaSum)
  );

  // --------------------------------------------------------------------------
  // Memory bus requests
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memBus <= '0;
    end else if (byteIn) begin
      memBus.req <= 1'b0;
    end else if (fetching && !memBus.req) begin
      memBus.req <= 1'b1;
      memBus.addr <= fetchAddr;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      pc <= `CAM_ADDR_RESET;
      prefix <= CAM_PFX_NONE;
      opcode <= 8'h00;
      mode <= CAM_INH;
      illegal <= 1'b0;
      opCnt <= 2'h0;
      opIdx <= 2'h0;
      ptrIdx <= 2'h0;
      byte0 <= 8'h00;
      byte1 <= 8'h00;
      ptr <= `CAM_ADDR_RESET;
      idxFirst <= 8'h00;
      idxSecond <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startReq) begin
            pc <= startPc;
            prefix <= CAM_PFX_NONE;
            idxFirst <= indexFirst;
            idxSecond <= indexSecond;
            state <= ST_OPCODE;
          end
        end
        ST_OPCODE: begin
          if (byteIn) begin
            pc <= pc + 16'h0001;
            if (prefixOf(memRdata) != CAM_PFX_NONE && prefix == CAM_PFX_NONE) begin
              prefix <= prefixOf(memRdata);
            end else begin
              opcode <= memRdata;
              mode <= modeIn;
              illegal <= badPrefix(rowIn, prefix) || (prefixOf(memRdata) != CAM_PFX_NONE);
              opCnt <= cntIn;
              opIdx <= 2'h0;
              ptrIdx <= 2'h0;
              ptr <= `CAM_ADDR_RESET;
              state <= (cntIn != 2'h0) ? ST_OPERAND : ST_CALC;
            end
          end
        end
        ST_OPERAND: begin
          if (byteIn) begin
            pc <= pc + 16'h0001;
            if (opIdx == 2'h0) begin
              byte0 <= memRdata;
            end else begin
              byte1 <= memRdata;
            end
            opIdx <= opIdx + 2'h1;
            if (opIdx == opCnt - 2'h1) begin
              state <= (pointerCount(mode) != 2'h0) ? ST_POINTER : ST_CALC;
            end
          end
        end
        ST_POINTER: begin
          if (byteIn) begin
            ptr <= {ptr[7:0], memRdata};
            ptrIdx <= ptrIdx + 2'h1;
            if (ptrIdx == pointerCount(mode) - 2'h1) begin
              state <= ST_CALC;
            end
          end
        end
        ST_CALC: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Answer to the sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      busy <= 1'b0;
      result <= '0;
    end else begin
      done <= (state == ST_DONE);
      busy <= (state != ST_IDLE) ? (state != ST_DONE) : startReq;
      if (state == ST_DONE) begin
        result.mode <= mode;
        result.length <= {1'b0, opCnt} + 3'h1 + {2'h0, prefix != CAM_PFX_NONE};
        result.effAddr <= eaSum;
        result.branchTarget <= pc + {{8{byte1[`CAM_SIGN_BIT]}}, byte1};
        result.useSecond <= useSecond;
        result.illegal <= illegal;
      end
    end
  end

  // Interrupt mask level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intMask <= `CAM_MASK_RESET;
    end else if (state == ST_DONE && !illegal) begin
      if (opcode == `CAM_OP_MASK_INTERRUPTS) begin
        intMask <= `CAM_MASK_LEVEL_SET;
      end else if (opcode == `CAM_OP_UNMASK_INTERRUPTS) begin
        intMask <= `CAM_MASK_LEVEL_CLEAR;
      end
    end
  end

endmodule : cam_addr_decoder

`default_nettype wire

//--- cam_addr_decoder_checker.sv
// Port-level assertions for the addressing mode decoder
`default_nettype none

module cam_addr_decoder_checker
  import cam_decoder_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sequencer side
  input wire logic startReq,
  input wire logic [15:0] startPc,
  input wire logic [7:0] indexFirst,
  input wire logic [7:0] indexSecond,
  input wire logic busy,
  input wire logic done,
  input wire cam_result_t result,
  input wire logic [1:0] intMask,
  // Memory side
  input wire cam_mem_req_t memBus,
  input wire logic [7:0] memRdata,
  input wire logic memAck
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------------
  // Decode results
  // ----------------------------------------------------------------------------
  a_inherent_len: assert property (done && result.mode == CAM_INH && !result.useSecond && !result.illegal
    |-> result.length == 3'h1) else $error("inherent length wrong");
  a_immediate_len: assert property (done && result.mode == CAM_IMM
    |-> result.length == 3'h2 + {2'h0, result.useSecond}) else $error("immediate length wrong");
  a_short_direct: assert property (done && result.mode inside {CAM_DIR_S, CAM_BIT_D}
    |-> result.effAddr[15:8] == 8'h00 && result.length == 3'h2) else $error("short direct wrong");
  a_long_direct: assert property (done && result.mode == CAM_DIR_L
    |-> result.length == 3'h3) else $error("long direct length wrong");
  a_noofs_index: assert property (done && result.mode == CAM_IDX_0
    |-> result.effAddr == {8'h00, result.useSecond ? indexSecond : indexFirst}) else $error("index alone wrong");
  a_short_reach: assert property (done && result.mode inside {CAM_IDX_S, CAM_IIX_S}
    |-> result.effAddr <= 16'h01fe) else $error("short indexed out of reach");
  a_short_indirect: assert property (done && result.mode == CAM_IND_S
    |-> result.effAddr[15:8] == 8'h00 && result.length == 3'h3) else $error("short indirect wrong");
  a_mask_level: assert property ($changed(intMask)
    |-> done && result.mode == CAM_INH && !result.illegal) else $error("mask changed outside a decode end");

  // ----------------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------------
  a_req_hold: assert property (memBus.req && !memAck
    |=> memBus.req && $stable(memBus.addr)) else $error("request dropped early");
  a_req_gap: assert property (memBus.req && memAck |=> !memBus.req) else $error("no gap after read");
  a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
  a_start_taken: assert property (startReq && !busy |=> busy) else $error("start not taken");
  a_busy_bound: assert property ($rose(busy) |-> ##[3:80] done) else $error("decode did not finish");

  c_long_iix: cover property (done && result.mode == CAM_IIX_L);
  c_second: cover property (done && result.useSecond);
  c_stall: cover property (memBus.req && !memAck);
  c_illegal: cover property (done && result.illegal);
endmodule : cam_addr_decoder_checker

`default_nettype wire

//--- cam_mem_model.sv
// Program and data memory answering the decoder's reads
`default_nettype none

module cam_mem_model
  import cam_decoder_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request side
  input wire cam_mem_req_t memBus,
  input wire logic [1:0] waitCycles,
  // Answer side
  output logic [7:0] memRdata,
  output logic memAck
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [0:65535];
  logic [1:0] waitCnt;
  logic [7:0] lastData;

  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask : poke

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end

  assign memAck = memBus.req && (waitCnt == waitCycles);
  // Idle bus shows inverted last byte, never a stale match
  assign memRdata = memAck ? mem[memBus.addr] : ~lastData;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 2'h0;
      lastData <= 8'h00;
    end else if (memAck) begin
      waitCnt <= 2'h0;
      lastData <= memRdata;
    end else if (memBus.req) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule : cam_mem_model

`default_nettype wire

//--- cam_addr_decoder_bench.sv
// Self-checking bench for the addressing mode decoder
`default_nettype none

module cam_addr_decoder_bench
  import cam_decoder_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [31:0] code;
    logic [15:0] ptr;
    cam_mode_t mode;
    logic [2:0] len;
    logic [15:0] ea;
    logic sec;
  } cam_row_t;

  logic ref_clk;
  logic rst_n;
  logic startReq;
  logic [15:0] startPc;
  logic [7:0] indexFirst;
  logic [7:0] indexSecond;
  logic busy;
  logic done;
  cam_result_t result;
  logic [1:0] intMask;
  cam_mem_req_t memBus;
  logic [7:0] memRdata;
  logic memAck;
  logic [1:0] waitCycles;
  int nFail = 0;
  int numChecks = 0;

  // ----------------------------------------------------------------------------
  // Ordinary cases, code bytes at 2000 + 8*row, pointer at 0040
  // ----------------------------------------------------------------------------
  cam_row_t rows [23] = '{
    '{32'h9d000000, 16'h0000, CAM_INH, 3'h1, 16'h0000, 1'b0},
    '{32'ha6550000, 16'h0000, CAM_IMM, 3'h2, 16'h2009, 1'b0},
    '{32'hb6800000, 16'h0000, CAM_DIR_S, 3'h2, 16'h0080, 1'b0},
    '{32'hc6123400, 16'h0000, CAM_DIR_L, 3'h3, 16'h1234, 1'b0},
    '{32'hf6000000, 16'h0000, CAM_IDX_0, 3'h1, 16'h00c3, 1'b0},
    '{32'h90f60000, 16'h0000, CAM_IDX_0, 3'h2, 16'h007e, 1'b1},
    '{32'he6ff0000, 16'h0000, CAM_IDX_S, 3'h2, 16'h01c2, 1'b0},
    '{32'hd612f000, 16'h0000, CAM_IDX_L, 3'h3, 16'h13b3, 1'b0},
    '{32'h92b64000, 16'h9a00, CAM_IND_S, 3'h3, 16'h009a, 1'b0},
    '{32'h92c64000, 16'habcd, CAM_IND_L, 3'h3, 16'habcd, 1'b0},
    '{32'h92e64000, 16'hf000, CAM_IIX_S, 3'h3, 16'h01b3, 1'b0},
    '{32'h91e64000, 16'hf000, CAM_IIX_S, 3'h3, 16'h016e, 1'b1},
    '{32'h92d64000, 16'h1234, CAM_IIX_L, 3'h3, 16'h12f7, 1'b0},
    '{32'h20fe0000, 16'h0000, CAM_REL_D, 3'h2, 16'h2068, 1'b0},
    '{32'h92204000, 16'h0500, CAM_REL_I, 3'h3, 16'h2078, 1'b0},
    '{32'h3c800000, 16'h0000, CAM_DIR_S, 3'h2, 16'h0080, 1'b0},
    '{32'h7c000000, 16'h0000, CAM_IDX_0, 3'h1, 16'h00c3, 1'b0},
    '{32'h6c100000, 16'h0000, CAM_IDX_S, 3'h2, 16'h00d3, 1'b0},
    '{32'h10800000, 16'h0000, CAM_BIT_D, 3'h2, 16'h0080, 1'b0},
    '{32'h00800500, 16'h0000, CAM_BIT_DR, 3'h3, 16'h0080, 1'b0},
    '{32'h92104000, 16'h7700, CAM_BIT_I, 3'h3, 16'h0077, 1'b0},
    '{32'h92004005, 16'h7700, CAM_BIT_IR, 3'h4, 16'h0077, 1'b0},
    '{32'h90a65500, 16'h0000, CAM_IMM, 3'h3, 16'h20b2, 1'b1}
  };

  cam_addr_decoder DUT (.ref_clk(ref_clk), .rst_n(rst_n), .startReq(startReq), .startPc(startPc),
    .indexFirst(indexFirst), .indexSecond(indexSecond), .busy(busy), .done(done), .result(result),
    .intMask(intMask), .memBus(memBus), .memRdata(memRdata), .memAck(memAck));

  cam_mem_model MEM (.ref_clk(ref_clk), .rst_n(rst_n), .memBus(memBus), .waitCycles(waitCycles),
    .memRdata(memRdata), .memAck(memAck));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic giveVerdict();
    $display("checks %0d failures %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : giveVerdict

  task automatic wait_done();
    for (int t = 0; t < 100 && done !== 1'b1; t++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("done", 16'h0001, {15'h0, done});
  endtask : wait_done

  // Loads bytes, starts a decode and waits for its end
  task automatic run_code(input logic [15:0] pc, input logic [31:0] code, input logic [15:0] ptr,
      input logic [1:0] w, input logic hold);
    for (int k = 0; k < 4; k++) begin
      MEM.poke(pc + 16'(k), code[31 - 8 * k -: 8]);
    end
    MEM.poke(16'h0040, ptr[15:8]);
    MEM.poke(16'h0041, ptr[7:0]);
    @(posedge ref_clk);
    waitCycles <= w;
    startPc <= pc;
    startReq <= 1'b1;
    @(posedge ref_clk);
    startReq <= hold;
    wait_done();
  endtask : run_code

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (8000) @(posedge ref_clk);
    nFail++;
    giveVerdict();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    startReq = 1'b0;
    startPc = 16'h0000;
    indexFirst = 8'hc3;
    indexSecond = 8'h7e;
    waitCycles = 2'h0;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("reset mask", 16'h0003, {14'h0, intMask});
    chk("reset busy", 16'h0000, {14'h0, busy, done});
    chk("reset req", 16'h0000, {15'h0, memBus.req});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 23; i++) begin
      run_code(16'h2000 + 16'(i * 8), rows[i].code, rows[i].ptr, 2'(i % 3), 1'b0);
      chk("mode", 16'(rows[i].mode), 16'(result.mode));
      chk("length", {13'h0, rows[i].len}, {13'h0, result.length});
      chk("second", {15'h0, rows[i].sec}, {15'h0, result.useSecond});
      chk("illegal", 16'h0000, {15'h0, result.illegal});
      if (rows[i].mode != CAM_INH) begin
        chk("address", rows[i].ea, result.effAddr);
      end
      if (i == 19 || i == 21) begin
        chk("branch", (i == 19) ? 16'h20a0 : 16'h20b1, result.branchTarget);
      end
    end
    // Mask levels, and no change from a bad prefix
    run_code(16'h3000, 32'h9a000000, 16'h0000, 2'h1, 1'b0);
    @(posedge ref_clk);
    #1;
    chk("mask clear", 16'h0000, {14'h0, intMask});
    run_code(16'h3008, 32'h9b000000, 16'h0000, 2'h0, 1'b0);
    @(posedge ref_clk);
    #1;
    chk("mask set", 16'h0003, {14'h0, intMask});
    run_code(16'h3010, 32'h919a0000, 16'h0000, 2'h0, 1'b0);
    @(posedge ref_clk);
    #1;
    chk("bad prefix", 16'h0001, {15'h0, result.illegal});
    chk("mask kept", 16'h0003, {14'h0, intMask});
    run_code(16'h3018, 32'h91b64000, 16'h0000, 2'h2, 1'b0);
    chk("prefix on direct", 16'h0001, {15'h0, result.illegal});
    // Back to back: start held high through the done cycle
    run_code(16'h3020, 32'hf6000000, 16'h0000, 2'h0, 1'b1);
    @(posedge ref_clk);
    #1;
    chk("restart busy", 16'h0001, {15'h0, busy});
    @(posedge ref_clk);
    startReq <= 1'b0;
    wait_done();
    chk("restart address", 16'h00c3, result.effAddr);
    // Mask low again so that the reset value is seen to return
    run_code(16'h3038, 32'h9a000000, 16'h0000, 2'h0, 1'b0);
    chk("mask low before reset", 16'h0000, {14'h0, intMask});
    // Reset in mid decode
    MEM.poke(16'h3028, 8'h92);
    MEM.poke(16'h3029, 8'hc6);
    MEM.poke(16'h302a, 8'h40);
    @(posedge ref_clk);
    waitCycles <= 2'h3;
    startPc <= 16'h3028;
    startReq <= 1'b1;
    @(posedge ref_clk);
    startReq <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("mid reset mask", 16'h0003, {14'h0, intMask});
    chk("mid reset req", 16'h0000, {14'h0, memBus.req, busy});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    run_code(16'h3030, 32'hc6beef00, 16'h0000, 2'h1, 1'b0);
    chk("after reset", 16'hbeef, result.effAddr);
    giveVerdict();
  end
endmodule : cam_addr_decoder_bench

bind cam_addr_decoder cam_addr_decoder_checker CHK (.ref_clk(ref_clk), .rst_n(rst_n), .startReq(startReq),
  .startPc(startPc), .indexFirst(indexFirst), .indexSecond(indexSecond), .busy(busy), .done(done),
  .result(result), .intMask(intMask), .memBus(memBus), .memRdata(memRdata), .memAck(memAck));

`default_nettype wire
